// File: rtl/css_pkg.sv
// Shared types and constants of the coherent snoop sequencer.
// Assumes one clock domain; line addresses are already line-aligned.
`default_nettype none
package css_pkg;
  // Snoop response bit positions
  localparam int unsigned CR_W      = 5;
  localparam int unsigned CR_DATA   = 0;
  localparam int unsigned CR_DIRTY  = 2;
  localparam int unsigned CR_UNIQUE = 4;
  // Line address width and default beats per cache line
  localparam int unsigned LINE_W     = 26;
  localparam int unsigned LINE_BEATS = 4;

  typedef enum logic [4:0] {
    OP_RD_NOSNOOP = 5'h00, OP_RD_ONCE     = 5'h01, OP_RD_CLEAN   = 5'h02,
    OP_RD_NSD     = 5'h03, OP_RD_SHARED   = 5'h04, OP_RD_UNIQUE  = 5'h05,
    OP_CLN_UNIQUE = 5'h06, OP_MK_UNIQUE   = 5'h07, OP_CLN_SHARED = 5'h08,
    OP_CLN_INVAL  = 5'h09, OP_MK_INVAL    = 5'h0a, OP_WR_NOSNOOP = 5'h0b,
    OP_WR_UNIQUE  = 5'h0c, OP_WR_LINE_UNQ = 5'h0d, OP_WR_BACK    = 5'h0e,
    OP_WR_CLEAN   = 5'h0f, OP_WR_EVICT    = 5'h10, OP_EVICT      = 5'h11
  } css_op_t;

  // Snoop classes, each with its own stop condition
  typedef enum logic [1:0] {
    CL_NONE = 2'h0, CL_READ = 2'h1, CL_CSHARED = 2'h2, CL_UNIQ = 2'h3
  } css_class_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_PICK = 4'b0010, ST_WAIT = 4'b0100, ST_RESP = 4'b1000
  } css_state_t;

  typedef struct packed {
    css_op_t           op;
    logic [LINE_W-1:0] line;
    logic              line_sized;   // Exactly one cache line long
    logic              ns_cacheable; // Non-shareable, write-through or write-back
  } css_req_t;

  function automatic css_class_t css_class(input css_op_t op);
    case (op)
      OP_RD_ONCE, OP_RD_CLEAN, OP_RD_NSD, OP_RD_SHARED: css_class = CL_READ;
      OP_CLN_SHARED:                                    css_class = CL_CSHARED;
      OP_RD_UNIQUE, OP_CLN_UNIQUE, OP_MK_UNIQUE, OP_CLN_INVAL,
      OP_MK_INVAL, OP_WR_UNIQUE, OP_WR_LINE_UNQ:        css_class = CL_UNIQ;
      default:                                          css_class = CL_NONE;
    endcase
  endfunction

  function automatic logic css_stop(input css_class_t cl, input logic [CR_W-1:0] r);
    case (cl)
      CL_READ:    css_stop = r[CR_DATA] | r[CR_UNIQUE];
      CL_CSHARED: css_stop = r[CR_DIRTY] | r[CR_UNIQUE];
      CL_UNIQ:    css_stop = r[CR_UNIQUE];
      default:    css_stop = 1'b1;
    endcase
  endfunction

  function automatic logic css_is_read(input css_op_t op);
    css_is_read = (op <= OP_RD_UNIQUE);
  endfunction

  // Reads that the continuous line return covers
  function automatic logic css_cont_ok(input css_req_t r);
    case (r.op)
      OP_RD_CLEAN, OP_RD_SHARED, OP_RD_UNIQUE, OP_RD_NSD: css_cont_ok = 1'b1;
      OP_RD_ONCE:    css_cont_ok = r.line_sized;
      OP_RD_NOSNOOP: css_cont_ok = r.line_sized & r.ns_cacheable;
      default:       css_cont_ok = 1'b0;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: rtl/css_sequencer.sv
// Coherent snoop sequencer: orders requests, snoops cached masters, returns responses.
// Assumes one clock, masters hold requests until ready, and ack or snoop answers are pulses.
// Operation
// - One arbiter picks a single order for same-line requests, seen alike by everyone.
// - One request and one snoop are in flight at a time; up to ACK_D responses per master may await their ack.
// - A snoop arriving before the response orders ahead of the master's transaction.
// - A response arriving before any snoop orders the master's transaction first.
// - After a response starts, no same-line snoop to that master until its ack.
// - After a snoop, no same-line response to that master until its snoop answer.
// - Acknowledges cannot be stalled; they are taken in the cycle they appear.
// - With continuous line return, remaining beats follow the first without waiting.
// - Continuous return covers only exactly line-sized qualifying reads.
// - Read snoops stop on obtained data, WasUnique, or all caches snooped.
// - CleanShared snoops stop on PassDirty, WasUnique, or all caches snooped.
// - Unique and invalidating snoops stop on WasUnique or all caches snooped.
// - Never snoop the master that initiated the transaction.
// - Every accepted request gets a response.
`default_nettype none
module css_sequencer
  import css_pkg::*;
#(
  parameter int unsigned N          = 4,
  parameter int unsigned ACK_D      = 4,
  parameter int unsigned BEATS      = LINE_BEATS,
  parameter logic        CONT_READ  = 1'b0,
  parameter logic [N-1:0] CACHED    = '1
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [N-1:0]      req_valid,
  input  wire css_req_t          req_in [N],
  output logic [N-1:0]           req_ready,
  output logic [N-1:0]           snp_valid,
  output logic [LINE_W-1:0]      snp_line,
  input  wire logic [N-1:0]      cr_valid,
  input  wire logic [CR_W-1:0]   cr_resp [N],
  output logic [N-1:0]           rsp_valid,
  output logic                   rsp_last,
  input  wire logic              mem_beat_ok,
  input  wire logic [N-1:0]      rack,
  input  wire logic [N-1:0]      wack
);
  localparam int unsigned IW = (N > 1) ? $clog2(N) : 1;
  localparam int unsigned SW = (ACK_D > 1) ? $clog2(ACK_D) : 1;
  localparam int unsigned BW = $clog2(BEATS + 1);

  css_state_t        st_q, st_d;
  css_req_t          cur_q, cur_d;
  logic [IW-1:0]     init_q, init_d, tgt_q, tgt_d, rr_q, rr_d, win, pick;
  logic [N-1:0]      done_q, done_d, ready_q, ready_d, snp_q, snp_d, rsp_q, rsp_d;
  logic [BW-1:0]     beat_q, beat_d, nbeats;
  logic              last_q, last_d, found, any_elig, alloc, cont, beat_go;
  logic [N-1:0]      elig, blk;
  css_class_t        cls;

  // Pending-ack table, one row per master
  logic [ACK_D-1:0]  ack_v_q [N];
  logic [ACK_D-1:0]  ack_v_d [N];
  logic [ACK_D-1:0]  ack_rd_q [N];
  logic [ACK_D-1:0]  ack_rd_d [N];
  logic [LINE_W-1:0] ack_ln_q [N][ACK_D];
  logic [LINE_W-1:0] ack_ln_d [N][ACK_D];
  logic [SW-1:0]     free_slot;
  logic              slot_free;
  int unsigned       occ [N];

  assign req_ready = ready_q;
  assign snp_valid = snp_q;
  assign snp_line  = cur_q.line;
  assign rsp_valid = rsp_q;
  assign rsp_last  = last_q;

  // A master is blocked for snooping while it owes an ack for the current line
  for (genvar m = 0; m < N; m++) begin : g_blk
    always_comb begin
      blk[m] = 1'b0;
      occ[m] = 0;
      for (int k = 0; k < ACK_D; k++) begin
        if (ack_v_q[m][k] && ack_ln_q[m][k] == cur_q.line) begin
          blk[m] = 1'b1;
        end
        if (ack_v_q[m][k]) begin
          occ[m] = occ[m] + 1;
        end
      end
    end
  end

  assign cls    = css_class(cur_q.op);
  assign cont   = CONT_READ & css_cont_ok(cur_q);
  assign nbeats = (css_is_read(cur_q.op) && cur_q.line_sized) ? BW'(BEATS) : BW'(1);
  // Initiator never eligible; only masters that may cache the line
  assign elig   = CACHED & ~done_q & ~(N'(1) << init_q);

  // Sequencing state machine: serialising every request through one engine fixes one global order
  always_comb begin
    st_d    = st_q;
    cur_d   = cur_q;
    init_d  = init_q;
    tgt_d   = tgt_q;
    rr_d    = rr_q;
    done_d  = done_q;
    beat_d  = beat_q;
    ready_d = '0;
    snp_d   = '0;
    rsp_d   = '0;
    last_d  = 1'b0;
    alloc   = 1'b0;
    found   = 1'b0;
    win     = '0;
    any_elig = |elig;
    pick    = '0;
    // Round-robin arbiter, starting after the last winner
    for (int i = N - 1; i >= 0; i--) begin
      if (req_valid[(int'(rr_q) + i) % N]) begin
        found = 1'b1;
        win   = IW'((int'(rr_q) + i) % N);
      end
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = IW'(i);
      end
    end
    beat_go = (beat_q != '0) ? (cont || mem_beat_ok) : (mem_beat_ok && slot_free);
    case (st_q)
      ST_IDLE: begin
        if (found) begin
          cur_d        = req_in[win];
          init_d       = win;
          done_d       = '0;
          beat_d       = '0;
          ready_d[win] = 1'b1;
          rr_d         = (int'(win) == N - 1) ? '0 : IW'(win + 1'b1);
          st_d         = (css_class(req_in[win].op) == CL_NONE) ? ST_RESP : ST_PICK;
        end
      end
      ST_PICK: begin
        if (!any_elig) begin
          st_d = ST_RESP;
        end else if (!blk[pick]) begin
          snp_d[pick]  = 1'b1;
          done_d[pick] = 1'b1;
          tgt_d        = pick;
          st_d         = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // No response may leave while a snoop is unanswered
        if (cr_valid[tgt_q]) begin
          st_d = css_stop(cls, cr_resp[tgt_q]) ? ST_RESP : ST_PICK;
        end
      end
      ST_RESP: begin
        if (beat_go) begin
          rsp_d[init_q] = 1'b1;
          alloc         = (beat_q == '0);
          if (beat_q == nbeats - 1'b1) begin
            last_d = 1'b1;
            beat_d = '0;
            st_d   = ST_IDLE;
          end else begin
            beat_d = beat_q + 1'b1;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q    <= ST_IDLE;
      cur_q   <= '0;
      init_q  <= '0;
      tgt_q   <= '0;
      rr_q    <= '0;
      done_q  <= '0;
      beat_q  <= '0;
      ready_q <= '0;
      snp_q   <= '0;
      rsp_q   <= '0;
      last_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cur_q   <= cur_d;
      init_q  <= init_d;
      tgt_q   <= tgt_d;
      rr_q    <= rr_d;
      done_q  <= done_d;
      beat_q  <= beat_d;
      ready_q <= ready_d;
      snp_q   <= snp_d;
      rsp_q   <= rsp_d;
      last_q  <= last_d;
    end
  end

  // Ack table: acks retire the lowest-indexed entry of their kind with no stall
  always_comb begin
    ack_v_d   = ack_v_q;
    ack_rd_d  = ack_rd_q;
    ack_ln_d  = ack_ln_q;
    slot_free = 1'b0;
    free_slot = '0;
    for (int k = ACK_D - 1; k >= 0; k--) begin
      if (!ack_v_q[init_q][k]) begin
        slot_free = 1'b1;
        free_slot = SW'(k);
      end
    end
    for (int m = 0; m < N; m++) begin
      for (int k = 0; k < ACK_D; k++) begin
        if (rack[m] && ack_v_q[m][k] && ack_rd_q[m][k] &&
            (ack_v_q[m] & ack_rd_q[m] & ((ACK_D)'(1) << k) - 1'b1) == '0) begin
          ack_v_d[m][k] = 1'b0;
        end
        if (wack[m] && ack_v_q[m][k] && !ack_rd_q[m][k] &&
            (ack_v_q[m] & ~ack_rd_q[m] & ((ACK_D)'(1) << k) - 1'b1) == '0) begin
          ack_v_d[m][k] = 1'b0;
        end
      end
    end
    // Free slot was picked from the registered row, so it cannot collide with a retire
    if (alloc) begin
      ack_v_d[init_q][free_slot]  = 1'b1;
      ack_rd_d[init_q][free_slot] = css_is_read(cur_q.op);
      ack_ln_d[init_q][free_slot] = cur_q.line;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int m = 0; m < N; m++) begin
        ack_v_q[m]  <= '0;
        ack_rd_q[m] <= '0;
        for (int k = 0; k < ACK_D; k++) begin
          ack_ln_q[m][k] <= '0;
        end
      end
    end else begin
      ack_v_q  <= ack_v_d;
      ack_rd_q <= ack_rd_d;
      ack_ln_q <= ack_ln_d;
    end
  end

  // Checks on the ordering engine
  for (genvar m = 0; m < N; m++) begin : g_chk
    snoop_hold_a : assert property (
      @(posedge ref_clk) disable iff (!reset_n) snp_q[m] |-> !blk[m])
      else $error("Snoop sent to a master that still owes an ack for the line");
    ack_take_a : assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (rack[m] && !wack[m] && |(ack_v_q[m] & ack_rd_q[m]) && !(alloc && int'(init_q) == m))
      |=> occ[m] + 1 == $past(occ[m]))
      else $error("Read ack was not taken in its cycle");
    write_take_a : assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (wack[m] && !rack[m] && |(ack_v_q[m] & ~ack_rd_q[m]) && !(alloc && int'(init_q) == m))
      |=> occ[m] + 1 == $past(occ[m]))
      else $error("Write ack was not taken in its cycle");
  end

  resp_hold_a : assert property (
    @(posedge ref_clk) disable iff (!reset_n) (st_q == ST_WAIT) |-> (rsp_q == '0))
    else $error("Response given while a snoop is unanswered");
  no_self_snoop_a : assert property (
    @(posedge ref_clk) disable iff (!reset_n) (|snp_q) |-> !snp_q[init_q])
    else $error("Snoop directed to the initiating master");
  read_stop_a : assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (st_q == ST_WAIT && cls == CL_READ && cr_valid[tgt_q] && cr_resp[tgt_q][CR_DATA]) |=> st_q == ST_RESP)
    else $error("Read snooping did not stop on data");
  cshared_stop_a : assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (st_q == ST_WAIT && cls == CL_CSHARED && cr_valid[tgt_q] && cr_resp[tgt_q][CR_DIRTY]) |=> st_q == ST_RESP)
    else $error("Clean-shared snooping did not stop on dirty data");
  unique_go_on_a : assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (st_q == ST_WAIT && cls == CL_UNIQ && cr_valid[tgt_q] && !cr_resp[tgt_q][CR_UNIQUE])
    |=> st_q == ST_PICK ##1 (st_q == ST_RESP || |snp_q || st_q == ST_PICK))
    else $error("Unique snooping stopped without WasUnique");
  cont_beats_a : assert property (
    @(posedge ref_clk) disable iff (!reset_n) ((|rsp_q) && !last_q && cont) |=> (|rsp_q))
    else $error("Continuous line read paused between beats");
  grant_one_a : assert property (
    @(posedge ref_clk) disable iff (!reset_n) (|ready_q) |-> ($onehot(ready_q) && st_q != ST_IDLE))
    else $error("More than one request granted at once");
  // The first beat must leave a pending-ack entry behind, or later snoops would not be held
  ack_alloc_a : assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (alloc && !rack[init_q] && !wack[init_q]) |=> occ[init_q] == $past(occ[init_q]) + 1)
    else $error("Pending-ack entry not recorded with the first response beat");
endmodule
`default_nettype wire

// File: tb/css_master_model.sv
// Behavioural model of the cached masters around the sequencer.
// Assumes one clock; the bench sets the snoop answers and the answer and ack delays.
`default_nettype none
module css_master_model
  import css_pkg::*;
#(
  parameter int unsigned N = 4
) (
  input  wire logic            ref_clk,
  input  wire logic            reset_n,
  input  wire logic [N-1:0]    snp_valid,
  input  wire logic [N-1:0]    rsp_valid,
  input  wire logic            rsp_last,
  input  wire logic [CR_W-1:0] cfg [N],
  input  wire logic [3:0]      snp_dly,
  input  wire logic [3:0]      ack_dly,
  input  wire logic            rd_kind,
  output logic [N-1:0]         cr_valid,
  output logic [CR_W-1:0]      cr_resp [N],
  output logic [N-1:0]         rack,
  output logic [N-1:0]         wack
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned sc [N];
  int unsigned ac [N];
  logic        kind [N];

  // Answer bits flip between answers, so a stale value never passes for a fresh one
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < N; i++) begin
      if (!reset_n) begin
        sc[i] <= 0;
        ac[i] <= 0;
        kind[i] <= 1'b0;
        cr_valid[i] <= 1'b0;
        cr_resp[i] <= 5'h00;
        rack[i] <= 1'b0;
        wack[i] <= 1'b0;
      end else begin
        cr_valid[i] <= (sc[i] == 1);
        cr_resp[i] <= (sc[i] == 1) ? cfg[i] : ~cr_resp[i];
        if (snp_valid[i]) sc[i] <= snp_dly + 1;
        else if (sc[i] != 0) sc[i] <= sc[i] - 1;
        // Acks only after the last beat, for every transaction
        rack[i] <= (ac[i] == 1) && kind[i];
        wack[i] <= (ac[i] == 1) && !kind[i];
        if (rsp_valid[i] && rsp_last) begin
          ac[i] <= ack_dly + 1;
          kind[i] <= rd_kind;
        end else if (ac[i] != 0) ac[i] <= ac[i] - 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench of the coherent snoop sequencer with four cached masters.
// Assumes the master model answers snoops and acks; continuous line return is enabled.
`default_nettype none
module tb_top
  import css_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned NM = 4;
  localparam css_op_t RD_OPS [4] = '{OP_RD_ONCE, OP_RD_CLEAN, OP_RD_NSD, OP_RD_SHARED};
  localparam css_op_t UQ_OPS [7] = '{OP_RD_UNIQUE, OP_CLN_UNIQUE, OP_MK_UNIQUE, OP_CLN_INVAL,
                                     OP_MK_INVAL, OP_WR_UNIQUE, OP_WR_LINE_UNQ};
  localparam css_op_t NS_OPS [5] = '{OP_WR_NOSNOOP, OP_WR_BACK, OP_WR_CLEAN, OP_WR_EVICT, OP_EVICT};
  logic              ref_clk, reset_n, rsp_last, mem_beat_ok, mem_toggle, rd_kind, in_beats;
  logic [NM-1:0]     req_valid, req_ready, snp_valid, cr_valid, rsp_valid, rack, wack, pend;
  logic [LINE_W-1:0] snp_line;
  logic [LINE_W-1:0] pend_line [NM];
  css_req_t          req_in [NM];
  logic [CR_W-1:0]   cr_resp [NM];
  logic [CR_W-1:0]   cfg [NM];
  logic [3:0]        snp_dly, ack_dly;
  int                error_cnt, checks_done, cyc, snp_cnt, beats, gap;
  int unsigned       cur_m;

  css_sequencer #(.N(NM), .CONT_READ(1'b1)) css_sequencer_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid), .req_in(req_in),
    .req_ready(req_ready), .snp_valid(snp_valid), .snp_line(snp_line), .cr_valid(cr_valid),
    .cr_resp(cr_resp), .rsp_valid(rsp_valid), .rsp_last(rsp_last), .mem_beat_ok(mem_beat_ok),
    .rack(rack), .wack(wack));
  css_master_model #(.N(NM)) css_master_model_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .snp_valid(snp_valid), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .cfg(cfg), .snp_dly(snp_dly), .ack_dly(ack_dly), .rd_kind(rd_kind),
    .cr_valid(cr_valid), .cr_resp(cr_resp), .rack(rack), .wack(wack));

  always #5 ref_clk = ~ref_clk;

  // A stuttering data source exposes any beat that waits once a line read has begun
  always @(posedge ref_clk) mem_beat_ok <= mem_toggle ? ~mem_beat_ok : 1'b1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watch outputs mid-cycle, away from the edge where they change
  always @(negedge ref_clk) begin
    if (reset_n) begin
      snp_cnt += $countones(snp_valid);
      beats += $countones(rsp_valid);
      check({31'h0, snp_valid[cur_m]}, 32'h0);
      if (rsp_valid != '0) in_beats = !rsp_last;
      else if (in_beats) gap++;
      for (int m = 0; m < NM; m++) begin
        if (snp_valid[m] && pend[m]) check({31'h0, snp_line === pend_line[m]}, 32'h0);
        if (rack[m] | wack[m]) pend[m] = 1'b0;
        else if (rsp_valid[m] && !pend[m]) begin
          pend[m] = 1'b1;
          pend_line[m] = snp_line;
        end
      end
    end else begin
      // Trackers start clean out of reset
      pend = '0;
      in_beats = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      check(32'h1, 32'h0);
      summarize();
    end
  end

  task automatic set_cfg(input logic [CR_W-1:0] a, b, c, d);
    cfg[0] <= a;
    cfg[1] <= b;
    cfg[2] <= c;
    cfg[3] <= d;
  endtask

  // One whole transaction: request, snoops, beats; counts compared at the end
  task automatic run_txn(input int unsigned m, input css_op_t op, input logic lsz, ns,
                         input int exp_snp, exp_beats, input logic nogap);
    int n;
    cur_m = m;
    snp_cnt = 0;
    beats = 0;
    gap = 0;
    rd_kind <= (op <= OP_RD_UNIQUE);
    req_in[m] <= '{op: op, line: 26'h5, line_sized: lsz, ns_cacheable: ns};
    req_valid[m] <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!req_ready[m] && n < 100);
    @(posedge ref_clk);
    req_valid[m] <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(rsp_valid[m] && rsp_last) && n < 400);
    // Let the watcher count the last beat before the totals are judged
    @(posedge ref_clk);
    check({31'h0, n < 400}, 32'h1);
    check(snp_cnt, exp_snp);
    check(beats, exp_beats);
    if (nogap) check(gap, 32'h0);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_no_snoop();
    foreach (NS_OPS[i]) run_txn(0, NS_OPS[i], 1'b1, 1'b0, 0, 1, 1'b0);
    run_txn(3, OP_RD_NOSNOOP, 1'b0, 1'b0, 0, 1, 1'b0);
  endtask

  task automatic t_read_stop();
    set_cfg(5'h01, 5'h00, 5'h00, 5'h00);
    foreach (RD_OPS[i]) run_txn(1, RD_OPS[i], 1'b1, 1'b0, 1, 4, 1'b1);
    set_cfg(5'h04, 5'h00, 5'h10, 5'h00);
    run_txn(1, OP_RD_SHARED, 1'b1, 1'b0, 2, 4, 1'b1);
    set_cfg(5'h00, 5'h00, 5'h00, 5'h00);
    run_txn(1, OP_RD_ONCE, 1'b0, 1'b0, 3, 1, 1'b0);
  endtask

  task automatic t_clean_shared();
    set_cfg(5'h01, 5'h04, 5'h00, 5'h00);
    run_txn(3, OP_CLN_SHARED, 1'b1, 1'b0, 2, 1, 1'b0);
    set_cfg(5'h01, 5'h01, 5'h01, 5'h01);
    run_txn(3, OP_CLN_SHARED, 1'b1, 1'b0, 3, 1, 1'b0);
  endtask

  task automatic t_unique();
    set_cfg(5'h07, 5'h07, 5'h07, 5'h07);
    foreach (UQ_OPS[i]) run_txn(2, UQ_OPS[i], 1'b1, 1'b0, 3, (i == 0) ? 4 : 1, 1'b0);
    set_cfg(5'h10, 5'h00, 5'h00, 5'h00);
    run_txn(2, OP_CLN_INVAL, 1'b1, 1'b0, 1, 1, 1'b0);
  endtask

  // Two masters race for one line: one must be served completely before the other is granted
  task automatic t_race();
    int n, g1, g3, d1, d3;
    set_cfg(5'h10, 5'h10, 5'h10, 5'h10);
    cur_m = 2;
    snp_cnt = 0;
    beats = 0;
    rd_kind <= 1'b0;
    req_in[1] <= '{op: OP_CLN_UNIQUE, line: 26'h9, line_sized: 1'b1, ns_cacheable: 1'b0};
    req_in[3] <= '{op: OP_CLN_UNIQUE, line: 26'h9, line_sized: 1'b1, ns_cacheable: 1'b0};
    req_valid[1] <= 1'b1;
    req_valid[3] <= 1'b1;
    do begin
      @(negedge ref_clk);
      n++;
      if (req_ready[1]) g1 = n;
      if (req_ready[3]) g3 = n;
      if (rsp_valid[1] && rsp_last) d1 = n;
      if (rsp_valid[3] && rsp_last) d3 = n;
      @(posedge ref_clk);
      req_valid[1] <= (g1 == 0);
      req_valid[3] <= (g3 == 0);
    end while ((d1 == 0 || d3 == 0) && n < 400);
    check({31'h0, n < 400}, 32'h1);
    check({31'h0, (g1 < g3) ? (d1 < g3) : (d3 < g1)}, 32'h1);
    check(snp_cnt, 32'h2);
    check(beats, 32'h2);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_cont_return();
    run_txn(0, OP_RD_NOSNOOP, 1'b1, 1'b1, 0, 4, 1'b1);
    run_txn(0, OP_RD_NOSNOOP, 1'b1, 1'b0, 0, 4, 1'b0);
  endtask

  // Slow ack from master 2 while master 0 wants to snoop it on the same line
  task automatic t_ack_hold();
    set_cfg(5'h00, 5'h00, 5'h00, 5'h00);
    ack_dly <= 4'hf;
    run_txn(2, OP_RD_UNIQUE, 1'b1, 1'b0, 3, 4, 1'b1);
    run_txn(0, OP_RD_UNIQUE, 1'b1, 1'b0, 3, 4, 1'b1);
    ack_dly <= 4'h1;
    repeat (20) @(posedge ref_clk);
    check({28'h0, pend}, 32'h0);
  endtask

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    req_valid = '0;
    mem_toggle = 1'b0;
    rd_kind = 1'b0;
    snp_dly = 4'h2;
    ack_dly = 4'h1;
    cur_m = 0;
    foreach (req_in[i]) begin
      req_in[i] = '0;
      cfg[i] = '0;
    end
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    mem_toggle <= 1'b1;
    t_no_snoop();
    t_read_stop();
    t_clean_shared();
    t_unique();
    t_race();
    t_cont_return();
    t_ack_hold();
    summarize();
  end
endmodule
`default_nettype wire
